/* File: hw/png_gpio.v */
/*
 Twelve-pin and nine-pin general-purpose port block with a classic
 Wishbone register slave and per-pin alternate-function routing on the nine-pin port only.
 Assumes pad inputs are synchronous to clk and pads are resolved outside.
*/
`timescale 1ns/100ps
`default_nettype none
`include "png_defs.vh"

module png_gpio (
  input wire clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [11:0] p7PadIn,
  output wire [11:0] p7PadOut,
  output wire [11:0] p7PadOe,
  input wire [15:0] p9PadIn,
  output wire [15:0] p9PadOut,
  output wire [15:0] p9PadOe,
  input wire serialOneClockOut,
  input wire serialOneClockOe,
  output wire serialOneClockIn,
  input wire serialOneDataOut,
  output wire serialOneDataIn,
  input wire timerPCh0Output,
  output wire timerPCh0Input,
  input wire timerPCh1Output,
  output wire timerPCh1Input,
  input wire uartOneTransmit,
  output wire uartOneReceive,
  output wire keyReturnSix,
  output wire keyReturnSeven,
  output wire extInterruptFour,
  output wire extInterruptFive,
  output wire extInterruptSix,
  input wire clockOutputPin
);

  // ==========================================================
  // Register storage
  reg [7:0] p7DataLowQ;
  reg [3:0] p7DataHighQ;
  reg [7:0] p7DirLowQ;
  reg [3:0] p7DirHighQ;
  reg [15:0] p9DataQ;
  reg [15:0] p9DirQ;
  reg [15:0] p9ModeQ;
  reg [15:0] p9FselQ;
  reg [15:0] p9FextQ;
  reg ackQ;
  reg [31:0] rdDataQ;
  reg [31:0] rdDataD;

  wire [7:0] adrWord;
  wire busReq;
  wire wrEn;
  wire [11:0] p7Data;
  wire [11:0] p7Dir;
  wire [15:0] altOut;
  wire [15:0] altOe;

  // Merge the two low byte lanes into a 16-bit register.
  function [15:0] mergeHalf;
    input [15:0] old;
    input [15:0] wr;
    input [1:0] sel;
    begin
      mergeHalf = {sel[1] ? wr[15:8] : old[15:8], sel[0] ? wr[7:0] : old[7:0]};
    end
  endfunction

  // ==========================================================
  // Wishbone handshake
  assign adrWord = {wb_adr_i[7:2], 2'b00};
  assign busReq = wb_cyc_i & wb_stb_i;
  // A write lands on the edge where the master sees ack, matching its sampling point.
  assign wrEn = busReq & wb_we_i & ackQ;
  assign wb_ack_o = ackQ;
  assign wb_dat_o = rdDataQ;

  always @(posedge clk) begin
    if (!rst_n) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= busReq & ~ackQ;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      rdDataQ <= 32'h00000000;
    end else if (busReq & ~ackQ) begin
      rdDataQ <= rdDataD;
    end
  end

  // ==========================================================
  // Twelve-pin port registers
  // Only lane 0 is honoured, so a wide access cannot reach the neighbour.
  always @(posedge clk) begin
    if (!rst_n) begin
      p7DataLowQ <= `PNG_P7_DATA_RST;
    end else if (wrEn && adrWord == `PNG_OFF_P7_DATA_LOW && wb_sel_i[0]) begin
      p7DataLowQ <= wb_dat_i[7:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      p7DataHighQ <= `PNG_P7_DATA_HIGH_RST;
    end else if (wrEn && adrWord == `PNG_OFF_P7_DATA_HIGH && wb_sel_i[0]) begin
      p7DataHighQ <= wb_dat_i[3:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      p7DirLowQ <= `PNG_P7_DIR_RST;
    end else if (wrEn && adrWord == `PNG_OFF_P7_DIR_LOW && wb_sel_i[0]) begin
      p7DirLowQ <= wb_dat_i[7:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      p7DirHighQ <= `PNG_P7H_FIXED;
    end else if (wrEn && adrWord == `PNG_OFF_P7_DIR_HIGH && wb_sel_i[0]) begin
      p7DirHighQ <= wb_dat_i[3:0];
    end
  end

  assign p7Data = {p7DataHighQ, p7DataLowQ};
  assign p7Dir = {p7DirHighQ, p7DirLowQ};

  // ==========================================================
  // Nine-pin port registers
  always @(posedge clk) begin
    if (!rst_n) begin
      p9DataQ <= `PNG_P9_DATA_RST;
    end else if (wrEn && adrWord == `PNG_OFF_P9_DATA) begin
      p9DataQ <= mergeHalf(p9DataQ, wb_dat_i[15:0], wb_sel_i[1:0]) & `PNG_P9_IMPL;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      p9DirQ <= `PNG_P9_DIR_RST;
    end else if (wrEn && adrWord == `PNG_OFF_P9_DIR) begin
      p9DirQ <= mergeHalf(p9DirQ, wb_dat_i[15:0], wb_sel_i[1:0]) | ~`PNG_P9_IMPL;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      p9ModeQ <= `PNG_P9_MODE_RST;
    end else if (wrEn && adrWord == `PNG_OFF_P9_MODE) begin
      p9ModeQ <= mergeHalf(p9ModeQ, wb_dat_i[15:0], wb_sel_i[1:0]) & `PNG_P9_IMPL;
    end
  end

  // Software must load these before raising a mode bit; a zero code leaves the pin undriven.
  always @(posedge clk) begin
    if (!rst_n) begin
      p9FselQ <= `PNG_P9_FUNC_RST;
    end else if (wrEn && adrWord == `PNG_OFF_P9_FSEL) begin
      p9FselQ <= mergeHalf(p9FselQ, wb_dat_i[15:0], wb_sel_i[1:0]) & `PNG_P9_IMPL;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      p9FextQ <= `PNG_P9_FUNC_RST;
    end else if (wrEn && adrWord == `PNG_OFF_P9_FEXT) begin
      p9FextQ <= mergeHalf(p9FextQ, wb_dat_i[15:0], wb_sel_i[1:0]) & `PNG_P9_FEXT_IMPL;
    end
  end

  // ==========================================================
  // Read multiplexer
  // Data registers read the pad level, so an output pin returns what the board sees.
  always @* begin
    rdDataD = 32'h00000000;
    case (adrWord)
      `PNG_OFF_P7_DATA_LOW: begin
        rdDataD[7:0] = p7PadIn[7:0];
      end
      `PNG_OFF_P7_DATA_HIGH: begin
        rdDataD[3:0] = p7PadIn[11:8];
      end
      `PNG_OFF_P7_DIR_LOW: begin
        rdDataD[7:0] = p7DirLowQ;
      end
      `PNG_OFF_P7_DIR_HIGH: begin
        rdDataD[7:0] = {`PNG_P7H_FIXED, p7DirHighQ};
      end
      `PNG_OFF_P9_DATA: begin
        rdDataD[15:0] = p9PadIn & `PNG_P9_IMPL;
      end
      `PNG_OFF_P9_DIR: begin
        rdDataD[15:0] = p9DirQ;
      end
      `PNG_OFF_P9_MODE: begin
        rdDataD[15:0] = p9ModeQ;
      end
      `PNG_OFF_P9_FSEL: begin
        rdDataD[15:0] = p9FselQ;
      end
      `PNG_OFF_P9_FEXT: begin
        rdDataD[15:0] = p9FextQ;
      end
      default: begin
        rdDataD = 32'h00000000;
      end
    endcase
  end

  // ==========================================================
  // Alternate-function routing
  png_func_decode uDecode (
    .mode(p9ModeQ),
    .fsel(p9FselQ),
    .fext(p9FextQ),
    .padIn(p9PadIn),
    .serialOneClockOut(serialOneClockOut),
    .serialOneClockOe(serialOneClockOe),
    .serialOneDataOut(serialOneDataOut),
    .timerPCh0Output(timerPCh0Output),
    .timerPCh1Output(timerPCh1Output),
    .uartOneTransmit(uartOneTransmit),
    .clockOutputPin(clockOutputPin),
    .altOut(altOut),
    .altOe(altOe),
    .serialOneClockIn(serialOneClockIn),
    .serialOneDataIn(serialOneDataIn),
    .timerPCh0Input(timerPCh0Input),
    .timerPCh1Input(timerPCh1Input),
    .keyReturnSix(keyReturnSix),
    .keyReturnSeven(keyReturnSeven),
    .uartOneReceive(uartOneReceive),
    .extInterruptFour(extInterruptFour),
    .extInterruptFive(extInterruptFive),
    .extInterruptSix(extInterruptSix)
  );

  // ==========================================================
  // Pin cells
  // Unimplemented nine-pin positions hold data 0 and direction 1, so they never drive.
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : gPin
      png_pin_cell uP9 (
        .portData(p9DataQ[i]),
        .portInput(p9DirQ[i]),
        .altEn(p9ModeQ[i]),
        .altOut(altOut[i]),
        .altOe(altOe[i]),
        .padOut(p9PadOut[i]),
        .padOe(p9PadOe[i])
      );
      if (i < 12) begin : gP7
        png_pin_cell uP7 (
          .portData(p7Data[i]),
          .portInput(p7Dir[i]),
          .altEn(1'b0),
          .altOut(1'b0),
          .altOe(1'b0),
          .padOut(p7PadOut[i]),
          .padOe(p7PadOe[i])
        );
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* File: hw/png_defs.vh */
/*
 Register offsets, reset values, implemented-bit masks, pin positions and
 function-select codes for the twelve-pin and nine-pin port block.
 Assumes a Wishbone slave that decodes byte address bits 7:2.
*/
`ifndef PNG_DEFS_VH
`define PNG_DEFS_VH

// ==========================================================
// Register byte offsets, one 32-bit word each
`define PNG_OFF_P7_DATA_LOW 8'h00
`define PNG_OFF_P7_DATA_HIGH 8'h04
`define PNG_OFF_P7_DIR_LOW 8'h08
`define PNG_OFF_P7_DIR_HIGH 8'h0C
`define PNG_OFF_P9_DATA 8'h10
`define PNG_OFF_P9_DIR 8'h14
`define PNG_OFF_P9_MODE 8'h18
`define PNG_OFF_P9_FSEL 8'h1C
`define PNG_OFF_P9_FEXT 8'h20

// ==========================================================
// Reset values
`define PNG_P7_DATA_RST 8'h00
`define PNG_P7_DATA_HIGH_RST 4'h0
`define PNG_P7_DIR_RST 8'hFF
`define PNG_P9_DATA_RST 16'h0000
`define PNG_P9_DIR_RST 16'hFFFF
`define PNG_P9_MODE_RST 16'h0000
`define PNG_P9_FUNC_RST 16'h0000

// ==========================================================
// Implemented bits
`define PNG_P7H_FIXED 4'hF
`define PNG_P9_IMPL 16'hE3C3
`define PNG_P9_FEXT_IMPL 16'h20C3

// ==========================================================
// Nine-pin port pin positions
`define PNG_B_PIN0 0
`define PNG_B_PIN1 1
`define PNG_B_PIN6 6
`define PNG_B_PIN7 7
`define PNG_B_PIN8 8
`define PNG_B_PIN9 9
`define PNG_B_PIN13 13
`define PNG_B_PIN14 14
`define PNG_B_PIN15 15

// ==========================================================
// Function codes as {expansion bit, select bit}
`define PNG_CODE_A 2'b01
`define PNG_CODE_B 2'b10
`define PNG_CODE_C 2'b11

`endif

/* File: hw/png_pin_cell.v */
/*
 One port pin: chooses between port-mode drive and peripheral drive.
 Assumes the pad wire is resolved outside from padOut and padOe.
*/
`timescale 1ns/100ps
`default_nettype none

module png_pin_cell (
  input wire portData,
  input wire portInput,
  input wire altEn,
  input wire altOut,
  input wire altOe,
  output wire padOut,
  output wire padOe
);

  assign padOut = altEn ? altOut : portData;
  assign padOe = altEn ? altOe : ~portInput;

endmodule

`default_nettype wire

/* File: hw/png_func_decode.v */
/*
 Alternate-function decode for the nine-pin port.
 Assumes the peripherals sit beside it and take their inputs combinationally.
*/
`timescale 1ns/100ps
`default_nettype none
`include "png_defs.vh"

module png_func_decode (
  input wire [15:0] mode,
  input wire [15:0] fsel,
  input wire [15:0] fext,
  input wire [15:0] padIn,
  input wire serialOneClockOut,
  input wire serialOneClockOe,
  input wire serialOneDataOut,
  input wire timerPCh0Output,
  input wire timerPCh1Output,
  input wire uartOneTransmit,
  input wire clockOutputPin,
  output reg [15:0] altOut,
  output reg [15:0] altOe,
  output reg serialOneClockIn,
  output reg serialOneDataIn,
  output reg timerPCh0Input,
  output reg timerPCh1Input,
  output reg keyReturnSix,
  output reg keyReturnSeven,
  output reg uartOneReceive,
  output reg extInterruptFour,
  output reg extInterruptFive,
  output reg extInterruptSix
);

  wire [1:0] c0 = {fext[`PNG_B_PIN0], fsel[`PNG_B_PIN0]};
  wire [1:0] c1 = {fext[`PNG_B_PIN1], fsel[`PNG_B_PIN1]};
  wire [1:0] c6 = {fext[`PNG_B_PIN6], fsel[`PNG_B_PIN6]};
  wire [1:0] c7 = {fext[`PNG_B_PIN7], fsel[`PNG_B_PIN7]};
  wire [1:0] c13 = {fext[`PNG_B_PIN13], fsel[`PNG_B_PIN13]};

  // Prohibited codes leave the pin undriven, so a careless setup cannot fight the board.
  always @* begin
    altOut = 16'h0000;
    altOe = 16'h0000;
    serialOneClockIn = 1'b1;
    serialOneDataIn = 1'b1;
    timerPCh0Input = 1'b0;
    timerPCh1Input = 1'b0;
    keyReturnSix = 1'b1;
    keyReturnSeven = 1'b1;
    uartOneReceive = 1'b1;
    extInterruptFour = 1'b0;
    extInterruptFive = 1'b0;
    extInterruptSix = 1'b0;
    if (mode[`PNG_B_PIN0]) begin
      if (c0 == `PNG_CODE_A) keyReturnSix = padIn[`PNG_B_PIN0];
      if (c0 == `PNG_CODE_B) begin
        altOut[`PNG_B_PIN0] = uartOneTransmit;
        altOe[`PNG_B_PIN0] = 1'b1;
      end
    end
    if (mode[`PNG_B_PIN1]) begin
      if (c1 == `PNG_CODE_A || c1 == `PNG_CODE_B) keyReturnSeven = padIn[`PNG_B_PIN1];
      if (c1 == `PNG_CODE_B) uartOneReceive = padIn[`PNG_B_PIN1];
    end
    if (mode[`PNG_B_PIN6]) begin
      if (c6 == `PNG_CODE_B) timerPCh1Input = padIn[`PNG_B_PIN6];
      if (c6 == `PNG_CODE_C) begin
        altOut[`PNG_B_PIN6] = timerPCh1Output;
        altOe[`PNG_B_PIN6] = 1'b1;
      end
    end
    if (mode[`PNG_B_PIN7]) begin
      if (c7 == `PNG_CODE_A) serialOneDataIn = padIn[`PNG_B_PIN7];
      if (c7 == `PNG_CODE_B) timerPCh0Input = padIn[`PNG_B_PIN7];
      if (c7 == `PNG_CODE_C) begin
        altOut[`PNG_B_PIN7] = timerPCh0Output;
        altOe[`PNG_B_PIN7] = 1'b1;
      end
    end
    if (mode[`PNG_B_PIN8] && fsel[`PNG_B_PIN8]) begin
      altOut[`PNG_B_PIN8] = serialOneDataOut;
      altOe[`PNG_B_PIN8] = 1'b1;
    end
    if (mode[`PNG_B_PIN9] && fsel[`PNG_B_PIN9]) begin
      serialOneClockIn = padIn[`PNG_B_PIN9];
      altOut[`PNG_B_PIN9] = serialOneClockOut;
      altOe[`PNG_B_PIN9] = serialOneClockOe;
    end
    if (mode[`PNG_B_PIN13]) begin
      if (c13 == `PNG_CODE_A) extInterruptFour = padIn[`PNG_B_PIN13];
      if (c13 == `PNG_CODE_B) begin
        altOut[`PNG_B_PIN13] = clockOutputPin;
        altOe[`PNG_B_PIN13] = 1'b1;
      end
    end
    if (mode[`PNG_B_PIN14] && fsel[`PNG_B_PIN14]) extInterruptFive = padIn[`PNG_B_PIN14];
    if (mode[`PNG_B_PIN15] && fsel[`PNG_B_PIN15]) extInterruptSix = padIn[`PNG_B_PIN15];
  end

endmodule

`default_nettype wire

/* File: sim/png_board_model.sv */
/*
 Board side of the port pins: a pad the block drives shows the block's level,
 an undriven pad shows whatever level the board puts on it.
 Assumes the bench sets the board levels and changes them only at clock edges.
*/
`timescale 1ns/100ps
`default_nettype none
module png_board_model (
  input wire logic [11:0] p7PadOut,
  input wire logic [11:0] p7PadOe,
  input wire logic [11:0] ext7,
  input wire logic [15:0] p9PadOut,
  input wire logic [15:0] p9PadOe,
  input wire logic [15:0] ext9,
  output logic [11:0] p7PadIn,
  output logic [15:0] p9PadIn
);
  // ==========================================================
  // Pad resolution
  // No pull-ups are modelled, so a released pad never keeps the last driven level.
  assign p7PadIn = (p7PadOe & p7PadOut) | (~p7PadOe & ext7);
  assign p9PadIn = (p9PadOe & p9PadOut) | (~p9PadOe & ext9);
endmodule
`default_nettype wire

/* File: sim/png_gpio_monitor.sv */
/*
 Concurrent checks on the bus and pad ports of the port block.
 Assumes it is bound to png_gpio and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none
module png_gpio_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [11:0] p7PadIn,
  input wire logic [11:0] p7PadOe,
  input wire logic [15:0] p9PadIn,
  input wire logic [15:0] p9PadOut,
  input wire logic [15:0] p9PadOe
);
  // ==========================================================
  // Bus answer and read values
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rdAck = wb_ack_o && !wb_we_i;
  wire [5:0] word = wb_adr_i[7:2];

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no answer");
  ack_needs_req_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("ack without request");
  reset_inputs_a: assert property ($rose(rst_n) |-> p7PadOe == 12'h000 && p9PadOe == 16'h0000)
    else $error("pads driven after reset");
  unused_quiet_a: assert property (((p9PadOe | p9PadOut) & 16'h1C3C) == 16'h0000) else $error("unused pin active");
  p7_low_pad_a: assert property (rdAck && word == 6'h00 |-> {4'h0, wb_dat_o[7:0]} == ($past(p7PadIn) & 12'h0FF))
    else $error("low data read wrong");
  p7_high_zero_a: assert property (rdAck && word == 6'h01 |-> wb_dat_o[31:4] == 28'h0) else $error("high nibble set");
  p7_dir_ones_a: assert property (rdAck && word == 6'h03 |-> wb_dat_o[7:4] == 4'hF) else $error("high dir not one");
  p9_data_pad_a: assert property (rdAck && word == 6'h04 |-> wb_dat_o[15:0] == ($past(p9PadIn) & 16'hE3C3))
    else $error("nine-pin data read wrong");
  p9_dir_ones_a: assert property (rdAck && word == 6'h05 |-> (wb_dat_o[15:0] & 16'h1C3C) == 16'h1C3C)
    else $error("unused dir bit not one");

  cover property (wb_ack_o && wb_we_i);
  cover property (rdAck && word == 6'h04);
  cover property (p9PadOe[8] && p9PadOe[13]);
endmodule

bind png_gpio png_gpio_monitor u_mon (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .p7PadIn, .p7PadOe, .p9PadIn, .p9PadOut, .p9PadOe);
`default_nettype wire

/* File: sim/png_gpio_tb_top.sv */
/*
 Self-checking bench for the port block: register model, bus tasks,
 random port traffic and alternate-function routing.
 Assumes the design, its checker and the board model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module png_gpio_tb_top;
  logic clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [11:0] p7PadIn, p7PadOut, p7PadOe, ext7 = 0;
  logic [15:0] p9PadIn, p9PadOut, p9PadOe, ext9 = 0;
  logic serialOneClockOut = 0, serialOneClockOe = 0, serialOneDataOut = 0, timerPCh0Output = 0;
  logic timerPCh1Output = 0, uartOneTransmit = 0, clockOutputPin = 0;
  logic serialOneClockIn, serialOneDataIn, timerPCh0Input, timerPCh1Input, uartOneReceive;
  logic keyReturnSix, keyReturnSeven, extInterruptFour, extInterruptFive, extInterruptSix;
  int m[9] = '{0, 0, 'hFF, 'hFF, 0, 'hFFFF, 0, 0, 0};
  int n_mismatch = 0, comparisons = 0, cycles = 0, seed = 33, i;

  png_gpio dut (.*);
  png_board_model board (.*);

  always #25 clk = ~clk;

  // ==========================================================
  // Model, checks and bus tasks
  function automatic int ex(int a);
    int dir7, p7, d9;
    dir7 = {m[3][3:0], m[2][7:0]};
    p7 = ((~dir7 & {m[1][3:0], m[0][7:0]}) | (dir7 & ext7)) & 'hFFF;
    d9 = ~m[5] & 'hE3C3;
    case (a)
      0: return p7 & 'hFF;
      4: return p7 >> 8;
      8: return m[2];
      12: return m[3] | 'hF0;
      16: return ((d9 & m[4]) | (~d9 & ext9)) & 'hE3C3;
      20: return m[5] | 'h1C3C;
      24, 28: return m[a / 4] & 'hE3C3;
      32: return m[8] & 'h20C3;
      default: return 0;
    endcase
  endfunction

  task chk(string nm, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Entered at a clock edge; returns one idle cycle after the acknowledged edge.
  task bus(int a, logic w, logic [3:0] s, logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a[7:0];
    wb_sel_i <= s;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk);
  endtask

  task wr(int a, logic [3:0] s, logic [31:0] d);
    bus(a, 1, s, d);
    if (a < 16 && s[0]) m[a / 4] = d[7:0];
    if (a >= 16 && a < 36) begin
      if (s[0]) m[a / 4][7:0] = d[7:0];
      if (s[1]) m[a / 4][15:8] = d[15:8];
    end
  endtask

  task rd(int a);
    bus(a, 0, 4'hF, 0);
    chk($sformatf("reg %0h", a), q, ex(a));
  endtask

  task pins();
    chk("p7 oe", p7PadOe, ~{m[3][3:0], m[2][7:0]} & 'hFFF);
    chk("p7 out", p7PadOut, {m[1][3:0], m[0][7:0]});
    chk("p9 oe", p9PadOe, ~m[5] & 'hE3C3);
    chk("p9 out", p9PadOut, m[4] & 'hE3C3);
  endtask

  // Function bits are set with the pins in port mode, then mode is switched on.
  task cfg(int fs, int fe);
    wr(24, 4'h3, 0);
    wr(28, 4'h3, fs);
    wr(32, 4'h3, fe);
    wr(24, 4'h3, 'hE3C3);
    {serialOneClockOut, serialOneClockOe, serialOneDataOut, timerPCh0Output, timerPCh1Output,
      uartOneTransmit, clockOutputPin} <= 7'($random(seed));
    ext9 <= 16'($random(seed));
    @(posedge clk);
  endtask

  task final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    pins();
    for (int a = 0; a < 40; a += 4) rd(a);
    repeat (16) begin
      i = $unsigned($random(seed)) % 7;
      if (i == 6) i = 9;
      wr(i * 4, 4'($random(seed)), $random(seed));
      ext7 <= 12'($random(seed));
      ext9 <= 16'($random(seed));
      @(posedge clk);
      pins();
      for (int a = 0; a < 40; a += 4) rd(a);
    end
    repeat (4) begin
      cfg('hE383, 'h0040);
      chk("alt in", {keyReturnSix, keyReturnSeven, timerPCh1Input, serialOneDataIn, extInterruptFour,
        extInterruptFive, extInterruptSix}, {ext9[0], ext9[1], ext9[6], ext9[7], ext9[13], ext9[14], ext9[15]});
      chk("alt oe", p9PadOe, {6'h00, serialOneClockOe, 9'h100});
      chk("alt out", p9PadOut[9:8], {serialOneClockOut, serialOneDataOut});
      cfg('hC3C0, 'h20C3);
      chk("alt oe2", p9PadOe, {3'h1, 3'h0, serialOneClockOe, 9'h1C1});
      chk("alt out2", {p9PadOut[13], p9PadOut[7:6], p9PadOut[0]},
        {clockOutputPin, timerPCh0Output, timerPCh1Output, uartOneTransmit});
      chk("uart rx", uartOneReceive, ext9[1]);
      cfg('hC340, 'h20C3);
      chk("timer in", {p9PadOe[7], timerPCh0Input}, {1'b0, ext9[7]});
      for (int a = 24; a < 36; a += 4) rd(a);
    end
    wr(24, 4'h3, 0);
    pins();
    final_report();
  end
endmodule
`default_nettype wire
